/* power_switch_host.sv */
// Host serial controller with AXI4-Lite command registers
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
module power_switch_host
    import power_switch_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    power_link_if.host link,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum {IDLE, LOW, HIGH, LATCH} state_t;
    state_t state, next_state;
    logic [10:0] sreg, next_sreg;
    logic [3:0] bitcnt, next_bitcnt, div, next_div;
    logic aw_got, w_got, next_aw_got, next_w_got;
    logic [3:0] awaddr, next_awaddr;
    logic [10:0] wdata, next_wdata;
    logic bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic [2:0] flt_s, next_flt_s;
    logic dout, next_dout, sclk, next_sclk, slat, next_slat;
    logic wr_go;

    assign s_axi_awready = !aw_got && !bvalid;
    assign s_axi_wready = !w_got && !bvalid;
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rresp = rresp;
    assign s_axi_rdata = rdata;
    assign link.ser_data = dout;
    assign link.ser_clock = sclk;
    assign link.ser_latch = slat;

    always_comb
    begin
        next_flt_s = {flt_s[1:0], link.fault_flag_n};
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_awaddr = awaddr;
        next_wdata = wdata;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        next_state = state;
        next_sreg = sreg;
        next_bitcnt = bitcnt;
        next_div = div;
        next_dout = dout;
        next_sclk = sclk;
        next_slat = slat;
        wr_go = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_got = 1'b1;
            next_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_got = 1'b1;
            next_wdata = s_axi_wdata[10:0];
        end
        // Write completes once both halves are in and the link is idle
        if (aw_got && w_got && state == IDLE)
        begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            if (awaddr == REG_CMD)
            begin
                next_bresp = RESP_OKAY;
                wr_go = 1'b1;
            end
            else
            begin
                next_bresp = (awaddr == REG_STATUS) ? RESP_OKAY : RESP_SLVERR;
            end
        end
        if (bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rdata = 32'h0000_0000;
            next_rresp = RESP_OKAY;
            if (s_axi_araddr == REG_STATUS)
            begin
                next_rdata[STAT_BUSY] = (state != IDLE);
                next_rdata[STAT_FAULT] = (flt_s[2] == flt_s[1]) ? !flt_s[2] : 1'b0;
            end
            else if (s_axi_araddr != REG_CMD)
            begin
                next_rresp = RESP_SLVERR;
            end
        end
        else if (rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
        case (state)
            IDLE:
            begin
                if (wr_go)
                begin
                    next_sreg = wdata;
                    next_bitcnt = 4'h0;
                    next_div = 4'h0;
                    next_state = LOW;
                end
            end
            LOW:
            begin
                next_dout = sreg[10]; // [RULE_01] [RULE_20]
                next_div = div + 4'h1;
                if (div == HALF_COUNT - 4'h1)
                begin
                    next_div = 4'h0;
                    next_sclk = 1'b1;
                    next_state = HIGH;
                end
            end
            HIGH:
            begin
                next_div = div + 4'h1;
                if (div == HALF_COUNT - 4'h1)
                begin
                    next_div = 4'h0;
                    next_sclk = 1'b0;
                    next_sreg = {sreg[9:0], 1'b0};
                    next_bitcnt = bitcnt + 4'h1;
                    next_state = (bitcnt == 4'(WORD_BITS - 1)) ? LATCH : LOW;
                end
            end
            LATCH:
            begin
                next_slat = 1'b1; // [RULE_03]
                next_div = div + 4'h1;
                if (div == HALF_COUNT - 4'h1)
                begin
                    next_div = 4'h0;
                    next_slat = 1'b0;
                    next_state = IDLE;
                end
            end
            default: next_state = IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= IDLE;
            sreg <= WORD_RESET;
            bitcnt <= 4'h0;
            div <= 4'h0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            awaddr <= 4'h0;
            wdata <= WORD_RESET;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= 32'h0000_0000;
            flt_s <= 3'h7;
            dout <= 1'b0;
            sclk <= 1'b0;
            slat <= 1'b0;
        end
        else
        begin
            state <= next_state;
            sreg <= next_sreg;
            bitcnt <= next_bitcnt;
            div <= next_div;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            awaddr <= next_awaddr;
            wdata <= next_wdata;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            flt_s <= next_flt_s;
            dout <= next_dout;
            sclk <= next_sclk;
            slat <= next_slat;
        end
    end
endmodule
`default_nettype wire

/* power_switch_pkg.sv */
// Shared constants and types for the slot power switch link
`default_nettype none
package power_switch_pkg;
    localparam int WORD_BITS = 11;
    // Control word bit positions
    localparam int BIT_A_PROG0 = 0;
    localparam int BIT_A_PROG1 = 1;
    localparam int BIT_A_MAIN_LO = 2;
    localparam int BIT_A_MAIN_HI = 3;
    localparam int BIT_B_PROG0 = 4;
    localparam int BIT_B_PROG1 = 5;
    localparam int BIT_B_MAIN_HI = 6;
    localparam int BIT_B_MAIN_LO = 7;
    localparam int BIT_SHUTDOWN_N = 8;
    localparam int BIT_A_PROG_SEL = 9;
    localparam int BIT_B_PROG_SEL = 10;
    localparam logic [10:0] WORD_RESET = 11'h000;
    // Switch source encoding on each output
    localparam logic [2:0] SRC_HIZ = 3'h0;
    localparam logic [2:0] SRC_GND = 3'h1;
    localparam logic [2:0] SRC_3V3 = 3'h2;
    localparam int unsigned SRC_5V_I = 3;
    localparam logic [2:0] SRC_5V = 3'h3;
    localparam logic [2:0] SRC_12V = 3'h4;
    // Link clock divider: half period in aclk cycles (160 ns period)
    localparam int LINK_PERIOD_NS = 160;
    localparam int CLK_PERIOD_NS = 10;
    localparam int HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [3:0] HALF_COUNT = 4'(HALF_CYCLES);
    // Host register map (AXI4-Lite byte offsets)
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam int STAT_BUSY = 0;
    localparam int STAT_FAULT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* power_link_if.sv */
// Three-wire serial link between host controller and power switch
`default_nettype none
interface power_link_if;
    logic ser_data;
    logic ser_clock;
    logic ser_latch;
    logic fault_flag_n;
    modport host (output ser_data, output ser_clock, output ser_latch, input fault_flag_n);
    modport device (input ser_data, input ser_clock, input ser_latch, output fault_flag_n);
endinterface
`default_nettype wire

/* power_switch_device.sv */
// Power switch control logic: serial word capture and output decode
// What this block does
// [RULE_01] Shift data on each serial clock rise
// [RULE_02] Latch rise loads 11-bit word
// [RULE_03] Host latches before next clock rise
// [RULE_04] Standby low reduces current limit
// [RULE_05] Host programs outputs before standby
// [RULE_06] Host avoids latching during standby
// [RULE_07] Mode low dependent, high independent
// [RULE_08] Independent programming supply decode
// [RULE_09] Dependent programming supply follows main
// [RULE_10] Main supply decode; shutdown means Hi-Z
// [RULE_11] Reset closes only discharge switches
// [RULE_12] Grounded until reset off, word latched
// [RULE_13] Latch ignored during reset
// [RULE_14] Reset state at power-up
// [RULE_15] Fault flag on overcurrent or overtemperature
// [RULE_16] Shutdown bit zero forces Hi-Z
// [RULE_17] Fault active low; limit affected output
// [RULE_18] Overtemperature turns all outputs off
// [RULE_19] Break before make on source change; in reset the code switches straight to ground with no open cycle
// [RULE_20] Bit 10 shifted first, bit 0 last
`default_nettype none
module power_switch_device
    import power_switch_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    power_link_if.device link,
    input wire logic reset_hi,
    input wire logic reset_lo_n,
    input wire logic standby_n,
    input wire logic mode_independent,
    input wire logic [3:0] overcurrent,
    input wire logic overtemp,
    output logic [2:0] slot_a_main_supply,
    output logic [2:0] slot_b_main_supply,
    output logic [2:0] slot_a_prog_supply,
    output logic [2:0] slot_b_prog_supply,
    output logic [3:0] current_limit_low,
    output logic [3:0] limit_active
);
    // Three-stage synchronisers for pins
    logic [2:0] clk_s, lat_s, dat_s;
    logic [2:0] next_clk_s, next_lat_s, next_dat_s;
    logic clk_q, lat_q, next_clk_q, next_lat_q;
    logic [10:0] shift, word, next_shift, next_word;
    logic powered, next_powered;
    logic [2:0] cur [4];
    logic [2:0] next_cur [4];
    logic [2:0] target [4];
    logic in_reset, clk_rise, lat_rise;
    // Other pins, msb first: reset_hi, reset_lo_n, standby_n, mode, overtemp, overcurrent
    localparam logic [8:0] PIN_IDLE = 9'h0c0;
    logic [8:0] pins, pin_s1, pin_s2, pin_s3, pin_q;
    logic [8:0] next_pin_s1, next_pin_s2, next_pin_s3, next_pin_q;
    logic hold_gnd, next_hold_gnd;

    assign pins = {reset_hi, reset_lo_n, standby_n, mode_independent, overtemp, overcurrent};

    always_comb
    begin
        next_pin_s1 = pins;
        next_pin_s2 = pin_s1;
        next_pin_s3 = pin_s2;
        // A change counts once the second and third stages agree
        next_pin_q = (pin_s2 & pin_s3) | (pin_q & (pin_s2 ^ pin_s3));
        next_clk_s = {clk_s[1:0], link.ser_clock};
        next_lat_s = {lat_s[1:0], link.ser_latch};
        next_dat_s = {dat_s[1:0], link.ser_data};
        next_clk_q = (clk_s[2] == clk_s[1]) ? clk_s[1] : clk_q;
        next_lat_q = (lat_s[2] == lat_s[1]) ? lat_s[1] : lat_q;
        clk_rise = next_clk_q && !clk_q;
        lat_rise = next_lat_q && !lat_q;
        in_reset = pin_q[8] || !pin_q[7] || !powered;
        next_powered = 1'b1;
        next_shift = shift;
        next_word = word;
        if (clk_rise)
        begin
            next_shift = {shift[9:0], dat_s[2]}; // [RULE_01] [RULE_20]
        end
        if (in_reset)
        begin
            next_word = WORD_RESET; // [RULE_13]
        end
        else if (lat_rise)
        begin
            next_word = shift; // [RULE_02]
        end
        // Held at ground from any reset until a word is latched
        next_hold_gnd = hold_gnd;
        if (in_reset)
        begin
            next_hold_gnd = 1'b1; // [RULE_12]
        end
        else if (lat_rise)
        begin
            next_hold_gnd = 1'b0; // [RULE_12]
        end
    end

    // Target source per output: 0 A main, 1 B main, 2 A prog, 3 B prog
    function automatic logic [2:0] main_src(input logic hi, input logic lo);
        case ({hi, lo})
            2'b01: main_src = SRC_3V3;
            2'b10: main_src = SRC_5V;
            default: main_src = SRC_GND;
        endcase // [RULE_10]
    endfunction

    function automatic logic [2:0] prog_src(input logic [1:0] sel, input logic extra,
                                            input logic indep, input logic [2:0] main);
        case (sel)
            2'b00: prog_src = SRC_GND;
            2'b01: prog_src = indep ? (extra ? SRC_5V : SRC_3V3) : main; // [RULE_07] [RULE_08] [RULE_09]
            2'b10: prog_src = SRC_12V;
            default: prog_src = SRC_HIZ;
        endcase
    endfunction

    always_comb
    begin
        target[0] = main_src(word[BIT_A_MAIN_HI], word[BIT_A_MAIN_LO]);
        target[1] = main_src(word[BIT_B_MAIN_HI], word[BIT_B_MAIN_LO]);
        target[2] = prog_src({word[BIT_A_PROG0], word[BIT_A_PROG1]}, word[BIT_A_PROG_SEL],
                             pin_q[5], target[0]);
        target[3] = prog_src({word[BIT_B_PROG0], word[BIT_B_PROG1]}, word[BIT_B_PROG_SEL],
                             pin_q[5], target[1]);
        for (int i = 0; i < 4; i++)
        begin
            if (in_reset || hold_gnd)
            begin
                target[i] = SRC_GND; // [RULE_11] [RULE_12] [RULE_14]
            end
            else if (!word[BIT_SHUTDOWN_N] || pin_q[4])
            begin
                target[i] = SRC_HIZ; // [RULE_16] [RULE_18]
            end
        end
        for (int i = 0; i < 4; i++)
        begin
            // Outside reset, open the old switch for one cycle before closing the new; in reset go straight to the target
            if (in_reset || cur[i] == target[i] || cur[i] == SRC_HIZ)
            begin
                next_cur[i] = target[i];
            end
            else
            begin
                next_cur[i] = SRC_HIZ; // [RULE_19]
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clk_s <= 3'h0;
            lat_s <= 3'h0;
            dat_s <= 3'h0;
            clk_q <= 1'b0;
            lat_q <= 1'b0;
            shift <= WORD_RESET;
            word <= WORD_RESET;
            powered <= 1'b0;
            pin_s1 <= PIN_IDLE;
            pin_s2 <= PIN_IDLE;
            pin_s3 <= PIN_IDLE;
            pin_q <= PIN_IDLE;
            hold_gnd <= 1'b1;
            for (int i = 0; i < 4; i++)
            begin
                cur[i] <= SRC_GND; // [RULE_14]
            end
        end
        else
        begin
            clk_s <= next_clk_s;
            lat_s <= next_lat_s;
            dat_s <= next_dat_s;
            clk_q <= next_clk_q;
            lat_q <= next_lat_q;
            shift <= next_shift;
            word <= next_word;
            powered <= next_powered;
            pin_s1 <= next_pin_s1;
            pin_s2 <= next_pin_s2;
            pin_s3 <= next_pin_s3;
            pin_q <= next_pin_q;
            hold_gnd <= next_hold_gnd;
            for (int i = 0; i < 4; i++)
            begin
                cur[i] <= next_cur[i];
            end
        end
    end

    assign slot_a_main_supply = cur[0];
    assign slot_b_main_supply = cur[1];
    assign slot_a_prog_supply = cur[2];
    assign slot_b_prog_supply = cur[3];
    // Status outputs follow the agreed pin values
    assign current_limit_low = {4{!pin_q[6]}}; // [RULE_04]
    assign limit_active = pin_q[3:0]; // [RULE_17]
    assign link.fault_flag_n = !((|pin_q[3:0]) || pin_q[4]); // [RULE_15] [RULE_17]
endmodule
`default_nettype wire

/* power_link_asserts.sv */
// Protocol checks on the serial link between host and device ends
`default_nettype none
module power_link_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ser_data,
    input wire logic ser_clock,
    input wire logic ser_latch,
    input wire logic fault_flag_n,
    input wire logic [3:0] overcurrent,
    input wire logic overtemp
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] bits;
    logic [3:0] next_bits;
    logic clk_q;
    logic next_clk_q;
    // Serial clock rises since the last latch
    always_comb
    begin
        next_clk_q = ser_clock;
        next_bits = bits;
        if (ser_latch)
            next_bits = 4'h0;
        else if (ser_clock && !clk_q)
            next_bits = bits + 4'h1;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bits <= 4'h0;
            clk_q <= 1'b0;
        end
        else
        begin
            bits <= next_bits;
            clk_q <= next_clk_q;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_clock_high;
        ser_clock [*8] ##1 !ser_clock;
    endsequence
    sequence s_latch_pulse;
        ser_latch [*7] ##1 !ser_latch;
    endsequence
    property p_data_stable;
        $rose(ser_clock) |-> $stable(ser_data);
    endproperty
    property p_clock_high;
        $rose(ser_clock) |-> s_clock_high;
    endproperty
    property p_clock_low;
        $fell(ser_clock) |-> !ser_clock [*8];
    endproperty
    property p_word_len;
        $rose(ser_latch) |-> bits == 4'hb;
    endproperty
    property p_latch_width;
        $rose(ser_latch) |-> s_latch_pulse;
    endproperty
    property p_latch_order;
        ser_latch |-> !ser_clock;
    endproperty
    property p_fault_on;
        (|overcurrent || overtemp) [*5] |-> !fault_flag_n;
    endproperty
    property p_fault_off;
        !(|overcurrent || overtemp) [*5] |-> fault_flag_n;
    endproperty
    a_data_stable: assert property (p_data_stable) else $error("data moved at clock rise");
    a_clock_high: assert property (p_clock_high) else $error("clock high phase wrong");
    a_clock_low: assert property (p_clock_low) else $error("clock low phase short");
    a_word_len: assert property (p_word_len) else $error("latch not after 11 bits");
    a_latch_width: assert property (p_latch_width) else $error("latch pulse width wrong");
    a_latch_order: assert property (p_latch_order) else $error("clock high during latch");
    a_fault_on: assert property (p_fault_on) else $error("fault flag not low");
    a_fault_off: assert property (p_fault_off) else $error("fault flag low spuriously");
endmodule
`default_nettype wire

/* tb_top.sv */
// Testbench joining host and device ends over the serial link
`default_nettype none
module tb_top;
    import power_switch_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic mode; logic [10:0] word; logic [11:0] exp;} row_t;
    localparam logic [11:0] V1 = {SRC_3V3, SRC_5V, SRC_5V, SRC_12V};
    localparam logic [11:0] GND4 = {4{SRC_GND}};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b1;
    logic [3:0] s_axi_araddr = 4'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b1;
    logic reset_hi = 1'b0;
    logic reset_lo_n = 1'b1;
    logic standby_n = 1'b1;
    logic mode = 1'b1;
    logic [3:0] overcurrent = 4'h0;
    logic overtemp = 1'b0;
    logic [2:0] a_main, b_main, a_prog, b_prog;
    logic [3:0] limit_low;
    logic [3:0] limit_act;
    logic [11:0] outs;
    logic [31:0] rd;
    logic [1:0] resp;
    int n_mismatch = 0;
    int samples_checked = 0;
    row_t rows [8];
    power_link_if link();
    assign outs = {a_main, b_main, a_prog, b_prog};
    always #5 aclk = ~aclk;
    power_switch_host u_power_switch_host (.aclk, .aresetn, .link(link),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    power_switch_device u_power_switch_device (.aclk, .aresetn, .link(link), .reset_hi,
        .reset_lo_n, .standby_n, .mode_independent(mode), .overcurrent, .overtemp,
        .slot_a_main_supply(a_main), .slot_b_main_supply(b_main),
        .slot_a_prog_supply(a_prog), .slot_b_prog_supply(b_prog),
        .current_limit_low(limit_low), .limit_active(limit_act));
    power_link_asserts u_power_link_asserts (.aclk(aclk), .aresetn(aresetn),
        .ser_data(link.ser_data), .ser_clock(link.ser_clock), .ser_latch(link.ser_latch),
        .fault_flag_n(link.fault_flag_n), .overcurrent(overcurrent), .overtemp(overtemp));
    task automatic stop_test();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        b_hs = 1'b0;
        while (!b_hs)
        begin
            @(negedge aclk);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_hs)
                s_axi_awvalid <= 1'b0;
            if (w_hs)
                s_axi_wvalid <= 1'b0;
        end
    endtask
    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hs, r_hs;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        r_hs = 1'b0;
        while (!r_hs)
        begin
            @(negedge aclk);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_hs)
                s_axi_arvalid <= 1'b0;
        end
    endtask
    task automatic send(input logic [10:0] w);
        axi_write(REG_CMD, {21'h0, w}, resp);
        for (int i = 0; i < 400; i++)
        begin
            axi_read(REG_STATUS, rd, resp);
            if (rd[STAT_BUSY] === 1'b0)
                break;
        end
        check(32'(rd[STAT_BUSY]), 32'h0);
        repeat (20) @(posedge aclk);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
    endtask
    initial
    begin
        #600000;
        n_mismatch++;
        stop_test();
    end
    initial
    begin
        rows = '{'{1'b1, 11'h356, V1},
            '{1'b1, 11'h5aa, {SRC_5V, SRC_3V3, SRC_3V3, SRC_5V}},
            '{1'b1, 11'h70f, {SRC_GND, SRC_GND, SRC_HIZ, SRC_GND}},
            '{1'b0, 11'h356, {SRC_3V3, SRC_5V, SRC_3V3, SRC_12V}},
            '{1'b0, 11'h5aa, {SRC_5V, SRC_3V3, SRC_5V, SRC_3V3}},
            '{1'b0, 11'h6ff, {4{SRC_HIZ}}},
            '{1'b1, 11'h256, {4{SRC_HIZ}}},
            '{1'b0, 11'h70f, {SRC_GND, SRC_GND, SRC_HIZ, SRC_GND}}};
        settle(4);
        aresetn <= 1'b1;
        settle(4);
        check(32'(outs), 32'(GND4));
        foreach (rows[i])
        begin
            mode <= rows[i].mode;
            send(rows[i].word);
            check(32'(outs), 32'(rows[i].exp));
        end
        mode <= 1'b1;
        reset_hi <= 1'b1;
        settle(10);
        check(32'(outs), 32'(GND4));
        send(11'h356);
        check(32'(outs), 32'(GND4));
        reset_hi <= 1'b0;
        settle(20);
        check(32'(outs), 32'(GND4));
        send(11'h356);
        check(32'(outs), 32'(V1));
        standby_n <= 1'b0;
        settle(6);
        check(32'(limit_low), 32'h0000000f);
        standby_n <= 1'b1;
        settle(6);
        check(32'(limit_low), 32'h0);
        overcurrent <= 4'h4;
        settle(8);
        check(32'(limit_act), 32'h4);
        check(32'(link.fault_flag_n), 32'h0);
        axi_read(REG_STATUS, rd, resp);
        check(32'(rd[STAT_FAULT]), 32'h1);
        overcurrent <= 4'h0;
        overtemp <= 1'b1;
        settle(10);
        check(32'(outs), 32'h0);
        overtemp <= 1'b0;
        settle(10);
        check(32'(outs), 32'(V1));
        reset_lo_n <= 1'b0;
        settle(10);
        check(32'(outs), 32'(GND4));
        reset_lo_n <= 1'b1;
        settle(10);
        check(32'(outs), 32'(GND4));
        axi_write(REG_CMD, 32'h5aa, resp);
        send(11'h356);
        check(32'(outs), 32'(V1));
        axi_read(4'h8, rd, resp);
        check(32'(resp), 32'(RESP_SLVERR));
        axi_write(4'hc, 32'h0, resp);
        check(32'(resp), 32'(RESP_SLVERR));
        axi_read(REG_CMD, rd, resp);
        check(rd, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
